/* File: dsrf_framer.v */
`timescale 1ns/100ps
`include "dsrf_map.vh"

// Notes on behaviour
// - Ack frame: STX, node, ACK, check, CR
// - Ack check covers node and ACK
// - Nak frame: STX, node, NAK, error, check, CR
// - Nak check covers node, error, NAK
// - Parity 01, overrun 04, buffer 07
// - Check 02, framing 03, command 11, 08, 13
// - Protocol 05, ASCII 06, parameter 16
// - Broadcast executes but never replies
// - Check is running XOR of covered bytes
// - Node and codes sent as ASCII hex
// - Speed 02 runs loopback test once per reset, when written
// - Speed defaults to 04, normal operation
// - Timeout drops partial query, no reply
// - Timeout applies selected error action
// - Timeout armed at first communication only
// - Timeout limit 0.00 to 99.99 s
// - Extra reply wait 0.0 to 1000 ms
// - Reply only after a query
// - Silent interval 3.5 characters long
module dsrf_framer #(
	parameter TICK_10MS = 2000000,
	parameter TICK_100US = 20000,
	parameter SILENT_CYC = 16'h0100
) (
	input wire REF_CLK,
	input wire NRST,
	input wire CLK_EN,
	input wire [3:0] ADDR,
	input wire [15:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [15:0] RDATA,
	input wire [7:0] NODE_ADDR,
	input wire QUERY_DONE,
	input wire QUERY_BCAST,
	input wire [`DSRF_EI_W-1:0] QUERY_ERR,
	input wire RX_ACTIVE,
	input wire RX_BYTE,
	output wire EXEC_CMD,
	output reg [7:0] TX_DATA,
	output reg TX_VALID,
	input wire TX_READY,
	output reg TX_BUSY,
	output wire LOOPBACK_MODE,
	output reg LOOPBACK_RUN,
	output reg COMM_TIMEOUT_TRIP,
	output reg STOP_COAST,
	output reg STOP_DECEL
);

	// ************************************************************
	// Reset release
	// ************************************************************
	reg rst_s1_q;
	reg rst_s2_q;
	wire rst_n;

	// Release reset through two flops
	always @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	// Only the second flop feeds the design
	assign rst_n = rst_s2_q;

	// ************************************************************
	// Registers
	// ************************************************************
	// Configuration held across queries, set back to defaults only by reset
	reg [7:0] link_speed_select_q;
	reg [2:0] comm_error_action_q;
	reg [13:0] reception_timeout_limit_q;
	reg [13:0] response_wait_time_q;
	reg loop_done_q;
	reg armed_q;

	// Software writes; limits saturate at documented maxima
	always @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			link_speed_select_q <= `DSRF_SPD_DEFAULT;
			comm_error_action_q <= `DSRF_ACT_TRIP;
			reception_timeout_limit_q <= 14'h0000;
			response_wait_time_q <= 14'h0000;
		end else if (CLK_EN && WR) begin
			case (ADDR)
			`DSRF_A_SPEED: link_speed_select_q <= WDATA[7:0];
			`DSRF_A_ACTION: comm_error_action_q <= WDATA[2:0];
			`DSRF_A_TIMEOUT: begin
				reception_timeout_limit_q <= (WDATA[13:0] > `DSRF_TO_MAX) ?
					`DSRF_TO_MAX : WDATA[13:0];
			end
			`DSRF_A_WAIT: begin
				response_wait_time_q <= (WDATA[13:0] > `DSRF_WAIT_MAX) ?
					`DSRF_WAIT_MAX : WDATA[13:0];
			end
			default: ;
			endcase
		end
	end

	// Read data one cycle after strobe; unmapped reads zero
	always @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			RDATA <= 16'h0000;
		end else if (CLK_EN) begin
			if (RD) begin
				case (ADDR)
				`DSRF_A_SPEED: RDATA <= {8'h00, link_speed_select_q};
				`DSRF_A_ACTION: RDATA <= {13'h0, comm_error_action_q};
				`DSRF_A_TIMEOUT: RDATA <= {2'h0, reception_timeout_limit_q};
				`DSRF_A_WAIT: RDATA <= {2'h0, response_wait_time_q};
				`DSRF_A_STATUS: begin
					RDATA <= {9'h0, loop_done_q, armed_q, STOP_DECEL, STOP_COAST,
						COMM_TIMEOUT_TRIP, LOOPBACK_RUN, TX_BUSY};
				end
				`DSRF_A_NODE: RDATA <= {8'h00, NODE_ADDR};
				default: RDATA <= 16'h0000;
				endcase
			end else begin
				RDATA <= 16'h0000;
			end
		end
	end

	// ************************************************************
	// Loopback self-test
	// ************************************************************
	// Loopback replaces normal replies while selected
	assign LOOPBACK_MODE = (link_speed_select_q == `DSRF_SPD_LOOPBACK);

	// Run the test once after each reset while speed selects loopback
	always @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			LOOPBACK_RUN <= 1'b0;
			loop_done_q <= 1'b0;
		end else if (CLK_EN) begin
			if (!loop_done_q && LOOPBACK_MODE) begin
				LOOPBACK_RUN <= 1'b1;
				if (RX_BYTE) begin
					loop_done_q <= 1'b1;
				end
			end else begin
				LOOPBACK_RUN <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Reception timeout
	// ************************************************************
	// Prescaler makes 10 ms steps; counter holds elapsed steps
	reg [31:0] to_pre_q;
	reg [13:0] to_cnt_q;
	wire to_hit;

	// Limit zero disables the timeout; count restarts after each hit
	assign to_hit = armed_q && RX_ACTIVE && (reception_timeout_limit_q != 14'h0000) &&
		(to_cnt_q >= reception_timeout_limit_q);

	// Arm at first received byte; count only while a query is in progress
	always @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
			to_pre_q <= 32'h00000000;
			to_cnt_q <= 14'h0000;
		end else if (CLK_EN) begin
			if (RX_BYTE) begin
				armed_q <= 1'b1;
			end
			if (!RX_ACTIVE || RX_BYTE || to_hit) begin
				to_pre_q <= 32'h00000000;
				to_cnt_q <= 14'h0000;
			end else if (armed_q) begin
				if (to_pre_q == TICK_10MS - 1) begin
					to_pre_q <= 32'h00000000;
					to_cnt_q <= to_cnt_q + 14'h0001;
				end else begin
					to_pre_q <= to_pre_q + 32'h00000001;
				end
			end
		end
	end

	// Error action after a timeout; trip held until software clears it
	always @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			COMM_TIMEOUT_TRIP <= 1'b0;
			STOP_COAST <= 1'b0;
			STOP_DECEL <= 1'b0;
		end else if (CLK_EN) begin
			if (to_hit) begin
				case (comm_error_action_q)
				`DSRF_ACT_TRIP: COMM_TIMEOUT_TRIP <= 1'b1;
				`DSRF_ACT_DECTRIP: begin
					STOP_DECEL <= 1'b1;
					COMM_TIMEOUT_TRIP <= 1'b1;
				end
				`DSRF_ACT_COAST: STOP_COAST <= 1'b1;
				`DSRF_ACT_DECEL: STOP_DECEL <= 1'b1;
				default: ;
				endcase
			// A new timeout in the same cycle wins over the clear
			end else if (WR && ADDR == `DSRF_A_CTRL && WDATA[`DSRF_CTRL_TRIPCLR]) begin
				COMM_TIMEOUT_TRIP <= 1'b0;
				STOP_COAST <= 1'b0;
				STOP_DECEL <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Reply framing
	// ************************************************************
	// Sequencer states
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_SEND = 2'h2;

	// Frame snapshot taken when a query is accepted, so inputs may move on
	reg [1:0] state_q;
	reg [31:0] wait_cnt_q;
	reg [3:0] idx_q;
	reg nak_q;
	reg [7:0] err_q;
	reg [7:0] node_q;
	reg [7:0] block_check_code_q;
	reg [7:0] err_code;
	reg [7:0] cur_byte;
	reg [3:0] last_idx;
	reg covered;
	integer i;

	// Lowest class index wins when several are flagged
	always @* begin
		err_code = 8'h00;
		// Scan from the top so the lowest flagged class is written last
		for (i = `DSRF_EI_W - 1; i >= 0; i = i - 1) begin
			if (QUERY_ERR[i]) begin
				case (i)
				`DSRF_EI_PARITY: err_code = `DSRF_ERR_PARITY;
				`DSRF_EI_OVERRUN: err_code = `DSRF_ERR_OVERRUN;
				`DSRF_EI_BUFOVF: err_code = `DSRF_ERR_BUFOVF;
				`DSRF_EI_CHECK: err_code = `DSRF_ERR_CHECK;
				`DSRF_EI_FRAMING: err_code = `DSRF_ERR_FRAMING;
				`DSRF_EI_CMD: err_code = `DSRF_ERR_CMD;
				`DSRF_EI_TIMEOUT: err_code = `DSRF_ERR_TIMEOUT;
				`DSRF_EI_EXECDIS: err_code = `DSRF_ERR_EXECDIS;
				`DSRF_EI_PROTOCOL: err_code = `DSRF_ERR_PROTOCOL;
				`DSRF_EI_ASCII: err_code = `DSRF_ERR_ASCII;
				default: err_code = `DSRF_ERR_PARAM;
				endcase
			end
		end
	end

	// Hex nibble to ASCII character
	function [7:0] hex_ascii;
		input [3:0] n;
		begin
			hex_ascii = (n < 4'ha) ? {4'h3, n} : (8'h37 + {4'h0, n});
		end
	endfunction

	// Byte sequence of the frame being sent, high character first
	always @* begin
		last_idx = nak_q ? 4'h8 : 4'h6;
		covered = 1'b0;
		case (idx_q)
		4'h0: cur_byte = `DSRF_CH_STX;
		4'h1: begin
			cur_byte = hex_ascii(node_q[7:4]);
			covered = 1'b1;
		end
		4'h2: begin
			cur_byte = hex_ascii(node_q[3:0]);
			covered = 1'b1;
		end
		4'h3: begin
			cur_byte = nak_q ? `DSRF_CH_NAK : `DSRF_CH_ACK;
			covered = 1'b1;
		end
		4'h4: begin
			cur_byte = nak_q ? hex_ascii(err_q[7:4]) : hex_ascii(block_check_code_q[7:4]);
			covered = nak_q;
		end
		4'h5: begin
			cur_byte = nak_q ? hex_ascii(err_q[3:0]) : hex_ascii(block_check_code_q[3:0]);
			covered = nak_q;
		end
		4'h6: cur_byte = nak_q ? hex_ascii(block_check_code_q[7:4]) : `DSRF_CH_CR;
		4'h7: cur_byte = hex_ascii(block_check_code_q[3:0]);
		default: cur_byte = `DSRF_CH_CR;
		endcase
	end

	// Execute error-free queries, broadcasts too; a timed-out query is dropped
	assign EXEC_CMD = CLK_EN && QUERY_DONE && (QUERY_ERR == {`DSRF_EI_W{1'b0}}) &&
		(state_q == ST_IDLE) && !LOOPBACK_MODE && !to_hit;

	// Reply sequencer: start only from a finished query, then wait, then send
	always @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			wait_cnt_q <= 32'h00000000;
			idx_q <= 4'h0;
			nak_q <= 1'b0;
			err_q <= 8'h00;
			node_q <= 8'h00;
			block_check_code_q <= 8'h00;
			TX_DATA <= 8'h00;
			TX_VALID <= 1'b0;
			TX_BUSY <= 1'b0;
		end else if (CLK_EN) begin
			case (state_q)
			ST_IDLE: begin
				TX_VALID <= 1'b0;
				TX_BUSY <= 1'b0;
				if (QUERY_DONE && !QUERY_BCAST && !LOOPBACK_MODE && !to_hit) begin
					state_q <= ST_WAIT;
					TX_BUSY <= 1'b1;
					nak_q <= (QUERY_ERR != {`DSRF_EI_W{1'b0}});
					err_q <= err_code;
					node_q <= NODE_ADDR;
					block_check_code_q <= 8'h00;
					wait_cnt_q <= SILENT_CYC + response_wait_time_q * TICK_100US;
					idx_q <= 4'h0;
				end
			end
			ST_WAIT: begin
				// Silent gap plus the programmed wait before the first byte
				if (wait_cnt_q == 32'h00000000) begin
					state_q <= ST_SEND;
				end else begin
					wait_cnt_q <= wait_cnt_q - 32'h00000001;
				end
			end
			ST_SEND: begin
				if (!TX_VALID || TX_READY) begin
					// Last byte taken: drop valid; busy falls on the next idle cycle
					if (TX_VALID && idx_q == last_idx + 4'h1) begin
						TX_VALID <= 1'b0;
						state_q <= ST_IDLE;
					end else if (idx_q <= last_idx) begin
						TX_DATA <= cur_byte;
						TX_VALID <= 1'b1;
						if (covered) begin
							block_check_code_q <= block_check_code_q ^ cur_byte;
						end
						idx_q <= idx_q + 4'h1;
					end else begin
						TX_VALID <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule

/* File: dsrf_map.vh */
`ifndef DSRF_MAP_VH
`define DSRF_MAP_VH
// Frame control characters
`define DSRF_CH_STX 8'h02
`define DSRF_CH_ACK 8'h06
`define DSRF_CH_NAK 8'h15
`define DSRF_CH_CR 8'h0d
// Error codes, two hex digits each
`define DSRF_ERR_PARITY 8'h01
`define DSRF_ERR_CHECK 8'h02
`define DSRF_ERR_FRAMING 8'h03
`define DSRF_ERR_OVERRUN 8'h04
`define DSRF_ERR_PROTOCOL 8'h05
`define DSRF_ERR_ASCII 8'h06
`define DSRF_ERR_BUFOVF 8'h07
`define DSRF_ERR_TIMEOUT 8'h08
`define DSRF_ERR_CMD 8'h11
`define DSRF_ERR_EXECDIS 8'h13
`define DSRF_ERR_PARAM 8'h16
// Error class indexes on the error input vector
`define DSRF_EI_PARITY 0
`define DSRF_EI_CHECK 1
`define DSRF_EI_FRAMING 2
`define DSRF_EI_OVERRUN 3
`define DSRF_EI_PROTOCOL 4
`define DSRF_EI_ASCII 5
`define DSRF_EI_BUFOVF 6
`define DSRF_EI_TIMEOUT 7
`define DSRF_EI_CMD 8
`define DSRF_EI_EXECDIS 9
`define DSRF_EI_PARAM 10
`define DSRF_EI_W 11
// Speed selection values
`define DSRF_SPD_LOOPBACK 8'h02
`define DSRF_SPD_DEFAULT 8'h04
// Error action values
`define DSRF_ACT_TRIP 3'h0
`define DSRF_ACT_DECTRIP 3'h1
`define DSRF_ACT_IGNORE 3'h2
`define DSRF_ACT_COAST 3'h3
`define DSRF_ACT_DECEL 3'h4
// Timing: clock rate and units
`define DSRF_CLK_HZ 200000000
`define DSRF_TO_STEP_S_DIV 100
`define DSRF_WAIT_STEP_S_DIV 10000
`define DSRF_TO_MAX 14'h270f
`define DSRF_WAIT_MAX 14'h2710
// Register map
`define DSRF_A_CTRL 4'h0
`define DSRF_A_SPEED 4'h1
`define DSRF_A_ACTION 4'h2
`define DSRF_A_TIMEOUT 4'h3
`define DSRF_A_WAIT 4'h4
`define DSRF_A_STATUS 4'h5
`define DSRF_A_NODE 4'h6
// Control bit positions
`define DSRF_CTRL_TRIPCLR 0
`endif

/* File: dsrf_framer_chk.sv */
`timescale 1ns/100ps
// ****
// Reply framer checks
// ****
module dsrf_framer_chk #(
	parameter TICK_10MS = 2000000,
	parameter TICK_100US = 20000,
	parameter SILENT_CYC = 16'h0100
) (
	input wire REF_CLK,
	input wire NRST,
	input wire CLK_EN,
	input wire QUERY_DONE,
	input wire QUERY_BCAST,
	input wire [10:0] QUERY_ERR,
	input wire EXEC_CMD,
	input wire [7:0] TX_DATA,
	input wire TX_VALID,
	input wire TX_READY,
	input wire TX_BUSY,
	input wire LOOPBACK_MODE
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// A query that the framer must answer
	sequence s_take;
		CLK_EN && QUERY_DONE && !QUERY_BCAST && !TX_BUSY && !LOOPBACK_MODE;
	endsequence
	// The silent gap before the first byte
	sequence s_quiet;
		(!TX_VALID)[*5];
	endsequence
	property p_take; s_take |=> TX_BUSY; endproperty
	a_take: assert property (p_take) else $error("reply not started");
	property p_quiet; s_take |=> s_quiet; endproperty
	a_quiet: assert property (p_quiet) else $error("reply too early");
	property p_bcast; QUERY_DONE && QUERY_BCAST && !TX_BUSY |=> !TX_BUSY; endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast answered");
	property p_loop; QUERY_DONE && LOOPBACK_MODE && !TX_BUSY |=> !TX_BUSY; endproperty
	a_loop: assert property (p_loop) else $error("reply in loopback");
	property p_idle; !TX_BUSY |-> !TX_VALID; endproperty
	a_idle: assert property (p_idle) else $error("byte while idle");
	property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
	a_hold: assert property (p_hold) else $error("byte not held");
	property p_exec; EXEC_CMD |-> QUERY_DONE && QUERY_ERR == 11'h000; endproperty
	a_exec: assert property (p_exec) else $error("bad execute");
	property p_end; TX_VALID && TX_READY && TX_DATA == 8'h0d |=> !TX_VALID; endproperty
	a_end: assert property (p_end) else $error("byte after end");
endmodule

bind dsrf_framer dsrf_framer_chk #(.TICK_10MS(TICK_10MS), .TICK_100US(TICK_100US),
	.SILENT_CYC(SILENT_CYC)) i_dsrf_framer_chk (.REF_CLK(REF_CLK), .NRST(NRST), .CLK_EN(CLK_EN),
	.QUERY_DONE(QUERY_DONE), .QUERY_BCAST(QUERY_BCAST), .QUERY_ERR(QUERY_ERR),
	.EXEC_CMD(EXEC_CMD), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
	.TX_BUSY(TX_BUSY), .LOOPBACK_MODE(LOOPBACK_MODE));

/* File: dsrf_host.sv */
`timescale 1ns/100ps
// ****
// Master side byte sink
// ****
module dsrf_host (
	input wire logic clk,
	input wire logic [3:0] slow,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready = 1'b0
);
	logic [7:0] got [$];
	logic [3:0] cnt = 4'h0;
	// Take each byte after a chosen stall
	always @(posedge clk) begin
		tx_ready <= 1'b0;
		cnt <= 4'h0;
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
		end else if (tx_valid && cnt >= slow) begin
			tx_ready <= 1'b1;
		end else if (tx_valid) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

/* File: tb_drive_serial_reply_framer.sv */
`timescale 1ns/100ps
// ****
// Reply framer bench
// ****
module tb_drive_serial_reply_framer;
	logic ref_clk = 0, nrst = 0, clk_en = 1, wr_s = 0, rd_s = 0;
	logic done = 0, bc = 0, rx_act = 0, rx_b = 0;
	logic [3:0] addr = 0, slow = 0;
	logic [15:0] wdata = 0;
	logic [7:0] node = 8'h32;
	logic [10:0] qe = 0;
	wire [15:0] rdata;
	wire [7:0] tx_data;
	wire exec, tx_valid, tx_ready, tx_busy, lb_mode, lb_run, trip, coast, decel;
	int err_total = 0, total_checks = 0, cyc = 0;
	logic [7:0] codes [11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
		8'h11, 8'h13, 8'h16};
	logic [2:0] aexp [5] = '{3'b100, 3'b101, 3'b000, 3'b010, 3'b001};
	dsrf_framer #(.TICK_10MS(10), .TICK_100US(2), .SILENT_CYC(16'h0004)) i_dsrf_framer (
		.REF_CLK(ref_clk), .NRST(nrst), .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata),
		.WR(wr_s), .RD(rd_s), .RDATA(rdata), .NODE_ADDR(node), .QUERY_DONE(done),
		.QUERY_BCAST(bc), .QUERY_ERR(qe), .RX_ACTIVE(rx_act), .RX_BYTE(rx_b),
		.EXEC_CMD(exec), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.TX_BUSY(tx_busy), .LOOPBACK_MODE(lb_mode), .LOOPBACK_RUN(lb_run),
		.COMM_TIMEOUT_TRIP(trip), .STOP_COAST(coast), .STOP_DECEL(decel));
	dsrf_host i_dsrf_host (.clk(ref_clk), .slow(slow), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready));
	// Clock and hang guard
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end
	// ****
	// Shared tasks
	// ****
	function automatic logic [7:0] hx(input logic [3:0] v);
		return v < 4'ha ? 8'h30 + v : 8'h37 + v;
	endfunction
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1;
		@(posedge ref_clk);
		wr_s <= 0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_s <= 1;
		@(posedge ref_clk);
		rd_s <= 0;
		#1 chk(rdata, e);
	endtask
	// One query; lat below zero means no reply is due
	task automatic q(input logic b, input logic [10:0] e, input logic [7:0] ec, input int lat);
		logic [7:0] body [$];
		logic [7:0] bcc;
		int n;
		i_dsrf_host.got.delete();
		@(posedge ref_clk);
		done <= 1;
		bc <= b;
		qe <= e;
		#1 if (lat >= 0 || b) chk(exec, e == 0);
		@(posedge ref_clk);
		done <= 0;
		#1 n = 0;
		while (tx_valid !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk(n, lat < 0 ? 400 : lat);
		if (lat < 0) return;
		n = 0;
		while (tx_busy !== 1'b0 && n < 400) begin
			@(posedge ref_clk);
			#1 n++;
		end
		body = '{hx(node[7:4]), hx(node[3:0]), ec ? 8'h15 : 8'h06};
		if (ec) body = {body, hx(ec[7:4]), hx(ec[3:0])};
		bcc = 0;
		foreach (body[i]) bcc ^= body[i];
		body = {8'h02, body, hx(bcc[7:4]), hx(bcc[3:0]), 8'h0d};
		chk(i_dsrf_host.got.size(), body.size());
		foreach (body[i]) chk(i_dsrf_host.got[i], body[i]);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_regs;
		rd(4'h1, 16'h0004);
		rd(4'hf, 16'h0000);
		rd(4'h5, 16'h0000);
		rd(4'h6, 16'h0032);
		chk(lb_run, 0);
	endtask
	// Clock enable low freezes writes and read data
	task automatic t_freeze;
		clk_en <= 0;
		wr(4'h1, 16'h0002);
		rd(4'h1, 16'h0032);
		clk_en <= 1;
		rd(4'h1, 16'h0004);
	endtask
	task automatic t_loop;
		wr(4'h1, 16'h0002);
		chk(lb_mode, 1);
		q(0, 0, 0, -1);
		chk(lb_run, 1);
		wr(4'h1, 16'h0004);
		chk(lb_mode, 0);
	endtask
	task automatic t_bcast;
		q(1, 0, 0, -1);
	endtask
	task automatic t_ack;
		slow <= 2;
		q(0, 0, 0, 6);
		slow <= 0;
	endtask
	task automatic t_nak;
		node <= 8'h01;
		for (int i = 0; i < 11; i++) q(0, 11'h7ff << i, codes[i], 6);
		node <= 8'h32;
	endtask
	task automatic t_wait;
		wr(4'h4, 16'h3fff);
		rd(4'h4, 16'h2710);
		wr(4'h4, 16'h0003);
		q(0, 0, 0, 12);
		wr(4'h4, 16'h0000);
	endtask
	// Timeout arming and every error action
	task automatic t_timeout;
		wr(4'h3, 16'h3fff);
		rd(4'h3, 16'h270f);
		wr(4'h3, 16'h0001);
		rx_act <= 1;
		repeat (30) @(posedge ref_clk);
		#1 chk(trip, 0);
		for (int a = 0; a < 5; a++) begin
			rx_act <= 1;
			wr(4'h2, a);
			@(posedge ref_clk);
			rx_b <= 1;
			@(posedge ref_clk);
			rx_b <= 0;
			repeat (20) @(posedge ref_clk);
			#1 chk({trip, coast, decel}, aexp[a]);
			chk(tx_busy, 0);
			rx_act <= 0;
			wr(4'h0, 16'h0001);
			chk({trip, coast, decel}, 0);
		end
		rd(4'h5, 16'h0020);
	endtask
	task automatic conclude;
		if (err_total == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		nrst <= 1;
		repeat (4) @(posedge ref_clk);
		t_regs();
		t_freeze();
		t_loop();
		t_bcast();
		t_ack();
		t_nak();
		t_wait();
		t_timeout();
		t_ack();
		conclude();
	end
endmodule
